// file: rtl/dif_core.sv
// decoder interrupt flags: source sync, change detect, sticky flags, masks, apb slave
`include "dif_regs.svh"

module dif_core (
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst_n,
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire dif_pkg::dif_addr_t i_paddr,
   input  wire dif_pkg::dif_word_t i_pwdata,
   input  wire logic [3:0]        i_pstrb,
   output      dif_pkg::dif_word_t o_prdata,
   output logic                   o_pready,
   output logic                   o_pslverr,
   input  wire logic              i_power_fail,
   input  wire logic              i_interlaced,
   input  wire logic              i_hpll_locked,
   input  wire logic              i_vert_locked,
   input  wire logic              i_field_60hz,
   input  wire logic              i_capture_ready,
   input  wire logic [1:0]        i_color_std,
   input  wire logic              i_copy_prot_a,
   input  wire logic              i_copy_prot_b,
   input  wire logic              i_copy_prot_c,
   input  wire logic              i_vps_ident,
   input  wire logic              i_widescreen_ident,
   input  wire logic              i_caption_ident,
   input  wire logic              i_scaler_format_err,
   output logic                   o_irq_n_out,
   output logic                   o_irq_n_oe
);
   import dif_pkg::*;

   // sources may come from other clock domains in the decoder
   dif_src_t  src_raw;
   dif_src_t  sync1_reg;
   dif_src_t  sync2_reg;
   dif_word_t live;
   dif_word_t prev_reg;
   dif_word_t prev_next;
   dif_word_t ev;

   dif_word_t mask_reg;
   dif_word_t mask_next;
   dif_word_t pend_reg;
   dif_word_t pend_next;
   dif_word_t clr;
   logic      irq_reg;
   logic      irq_next;

   dif_word_t prdata_reg;
   dif_word_t prdata_next;
   logic      pready_reg;
   logic      pready_next;
   logic      pslverr_reg;
   logic      pslverr_next;

   logic      setup;
   logic      acc;
   logic      hit;
   dif_grp_t  grp;
   logic [1:0] idx;

   // places the synchronised sources at their status bit positions
   function automatic dif_word_t dif_map(input dif_src_t s);
      dif_word_t w;
      w = `DIF_RST_WORD;
      w[`DIF_POS_INTERLACE_CHANGE_FLAG]    = s[0];
      w[`DIF_POS_HPLL]    = s[1];
      w[`DIF_POS_VLOCK]   = s[2];
      w[`DIF_POS_FIELD]   = s[3];
      w[`DIF_POS_CAPT]    = s[4];
      w[`DIF_POS_COLOR]   = s[5];
      w[`DIF_POS_COLOR+1] = s[6];
      w[`DIF_POS_CPA]     = s[7];
      w[`DIF_POS_CPB]     = s[8];
      w[`DIF_POS_CPC]     = s[9];
      w[`DIF_POS_VPS]     = s[10];
      w[`DIF_POS_WIDE]    = s[11];
      w[`DIF_POS_CAPTION] = s[12];
      w[`DIF_POS_PFAIL]   = s[13];
      w[`DIF_POS_SCERR]   = s[14];
      return w;
   endfunction : dif_map

   // selects the byte lane of one of the four 8-bit registers
   function automatic dif_word_t dif_lane(input logic [1:0] i);
      dif_word_t w;
      w = `DIF_RST_WORD;
      w[8*i +: 8] = 8'hff;
      return w;
   endfunction : dif_lane

   function automatic dif_byte_t dif_pick(input dif_word_t w,
                                          input logic [1:0] i);
      dif_byte_t b;
      b = w[8*i +: 8];
      return b;
   endfunction : dif_pick

   assign src_raw = {i_scaler_format_err, i_power_fail,
                     i_caption_ident, i_widescreen_ident, i_vps_ident,
                     i_copy_prot_c, i_copy_prot_b, i_copy_prot_a,
                     i_color_std, i_capture_ready, i_field_60hz,
                     i_vert_locked, i_hpll_locked, i_interlaced};

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_reg <= 15'h0000;
         sync2_reg <= 15'h0000;
      end else begin
         sync1_reg <= src_raw;
         sync2_reg <= sync1_reg;
      end
   end

   // status reads see this vector directly: no capture at event time
   assign live = dif_map(sync2_reg);

   // level sources flag any change, power fail and scaler error only their onset
   always_comb begin
      prev_next = live;
      ev = ((live ^ prev_reg) & ~`DIF_RISE_MASK)
         | (live & ~prev_reg & `DIF_RISE_MASK);
      ev = ev & `DIF_VALID_MASK;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_reg <= `DIF_RST_WORD;
      end else begin
         prev_reg <= prev_next;
      end
   end

   // apb decode: no wait state, read data is registered in the setup cycle so it comes from a flop
   always_comb begin
      setup = i_psel & ~i_penable;
      acc   = i_psel & i_penable & pready_reg;
      grp   = dif_grp_t'(i_paddr[5:4]);
      idx   = i_paddr[3:2];
      hit   = (i_paddr[7:6] == 2'b00) && (i_paddr[1:0] == 2'b00)
              && (i_paddr[5:4] != 2'b11);
   end

   always_comb begin
      pready_next  = setup;
      pslverr_next = 1'b0;
      prdata_next  = `DIF_RST_WORD;
      if (setup) begin
         pslverr_next = ~hit | (i_pwrite & (grp != DIF_GRP_MASK));
         if (hit && !i_pwrite) begin
            case (grp)
               DIF_GRP_STAT: prdata_next[7:0] = dif_pick(live, idx);
               DIF_GRP_MASK: prdata_next[7:0] = dif_pick(mask_reg, idx);
               DIF_GRP_PEND: prdata_next[7:0] = dif_pick(pend_reg, idx);
               default:      prdata_next      = `DIF_RST_WORD;
            endcase
         end
      end else if (i_psel) begin
         pslverr_next = pslverr_reg;
         prdata_next  = prdata_reg;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= `DIF_RST_WORD;
      end else begin
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg  <= prdata_next;
      end
   end

   assign o_pready  = pready_reg;
   assign o_pslverr = pslverr_reg & pready_reg;
   assign o_prdata  = prdata_reg;

   // masks, sticky flags and the interrupt line
   always_comb begin
      mask_next = mask_reg;
      clr       = `DIF_RST_WORD;
      if (acc && !pslverr_reg) begin
         if (i_pwrite && i_pstrb[0]) begin
            mask_next = (mask_reg & ~dif_lane(idx))
                      | (dif_lane(idx) & {4{i_pwdata[7:0]}} & `DIF_VALID_MASK);
         end
         if (!i_pwrite && grp == DIF_GRP_STAT) begin
            clr = dif_lane(idx);
         end
      end
      // set wins over the clearing read in the same cycle
      pend_next = (pend_reg & ~clr) | ev;
      irq_next  = |(pend_reg & mask_reg);
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mask_reg <= `DIF_RST_MASK;
         pend_reg <= `DIF_RST_PEND;
         irq_reg  <= 1'b0;
      end else begin
         mask_reg <= mask_next;
         pend_reg <= pend_next;
         irq_reg  <= irq_next;
      end
   end

   // open drain: only ever drives low, the board pull-up makes the high
   assign o_irq_n_out = 1'b0;
   assign o_irq_n_oe  = irq_reg;

   // ---- checks ----
   logic      mask_wr_seen_reg;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mask_wr_seen_reg <= 1'b0;
      end else if (acc && i_pwrite) begin
         mask_wr_seen_reg <= 1'b1;
      end
   end

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);

   sequence s_stat_read;
      i_psel && !i_penable && !i_pwrite && hit && grp == DIF_GRP_STAT;
   endsequence

   sequence s_read_done;
      i_psel && i_penable && pready_reg;
   endsequence

   a_irq_drive_low: assert property (
      o_irq_n_out == 1'b0 && o_irq_n_oe == $past(|(pend_reg & mask_reg)))
      else $error("irq pin not open drain of pending masked flags");

   a_irq_masked_off: assert property (
      (mask_reg == `DIF_RST_WORD) |=> !o_irq_n_oe)
      else $error("irq asserted with all masks clear");

   a_mask_reset: assert property (
      !mask_wr_seen_reg |-> mask_reg == `DIF_RST_MASK && !o_irq_n_oe)
      else $error("mask not clear before first write");

   a_power_flag: assert property (
      $rose(sync2_reg[13]) |=> pend_reg[`DIF_POS_PFAIL])
      else $error("power fail flag not raised");

   a_interlace_change_flag_change: assert property (
      $changed(sync2_reg[0]) |=> pend_reg[`DIF_POS_INTERLACE_CHANGE_FLAG])
      else $error("interlace change not flagged");

   a_hpll_change: assert property (
      $changed(sync2_reg[1]) |=> pend_reg[`DIF_POS_HPLL])
      else $error("hpll lock change not flagged");

   a_vlock_change: assert property (
      $changed(sync2_reg[2]) |=> pend_reg[`DIF_POS_VLOCK])
      else $error("vertical lock change not flagged");

   a_field_change: assert property (
      $changed(sync2_reg[3]) |=> pend_reg[`DIF_POS_FIELD])
      else $error("field rate change not flagged");

   a_capt_change: assert property (
      $changed(sync2_reg[4]) |=> pend_reg[`DIF_POS_CAPT])
      else $error("capture ready change not flagged");

   a_color_change: assert property (
      $changed(sync2_reg[6:5])
      |=> |pend_reg[`DIF_POS_COLOR +: 2])
      else $error("colour standard change not flagged");

   a_copy_change: assert property (
      $changed(sync2_reg[8]) |=> pend_reg[`DIF_POS_CPB])
      else $error("copy protection change not flagged");

   a_copy_a_change: assert property (
      $changed(sync2_reg[7]) |=> pend_reg[`DIF_POS_CPA])
      else $error("copy protection a change not flagged");

   a_copy_c_change: assert property (
      $changed(sync2_reg[9]) |=> pend_reg[`DIF_POS_CPC])
      else $error("copy protection c change not flagged");

   a_vps_change: assert property (
      $changed(sync2_reg[10]) |=> pend_reg[`DIF_POS_VPS])
      else $error("vps ident change not flagged");

   a_wide_change: assert property (
      $changed(sync2_reg[11]) |=> pend_reg[`DIF_POS_WIDE])
      else $error("widescreen ident change not flagged");

   a_cc_change: assert property (
      $changed(sync2_reg[12]) |=> pend_reg[`DIF_POS_CAPTION])
      else $error("caption ident change not flagged");

   a_scerr_flag: assert property (
      $rose(sync2_reg[14]) |=> pend_reg[`DIF_POS_SCERR])
      else $error("scaler error not flagged");

   a_live_status: assert property (
      s_stat_read |=> o_prdata[7:0] == dif_pick($past(live), $past(idx)))
      else $error("status read not live");

   a_byte_width: assert property (
      s_stat_read |=> o_pready ##0 o_prdata[31:8] == 24'h000000)
      else $error("status register wider than a byte");

   a_clear_cause: assert property (
      ($past(pend_reg) & ~pend_reg & ~$past(clr)) == `DIF_RST_WORD)
      else $error("flag cleared without its status read");

   a_set_wins: assert property (
      s_read_done ##0 (|(ev & clr))
      |=> (($past(ev & clr) & ~pend_reg) == `DIF_RST_WORD))
      else $error("event lost in clearing read");

   a_irq_or: assert property (
      (|(pend_reg & mask_reg)) |=> o_irq_n_oe)
      else $error("irq not raised for enabled pending flag");

endmodule : dif_core

// file: rtl/dif_regs.svh
// register map, field positions, event masks and reset values of the decoder interrupt flags
`ifndef DIF_REGS_SVH
`define DIF_REGS_SVH

`define DIF_OFF_STAT     8'h00
`define DIF_OFF_MASK     8'h10
`define DIF_OFF_PEND     8'h20

`define DIF_POS_INTERLACE_CHANGE_FLAG     0
`define DIF_POS_HPLL     1
`define DIF_POS_VLOCK    2
`define DIF_POS_FIELD    3
`define DIF_POS_CAPT     4
`define DIF_POS_COLOR    8
`define DIF_POS_CPA      10
`define DIF_POS_CPB      11
`define DIF_POS_CPC      12
`define DIF_POS_VPS      16
`define DIF_POS_WIDE     17
`define DIF_POS_CAPTION  18
`define DIF_POS_PFAIL    24
`define DIF_POS_SCERR    25

`define DIF_VALID_MASK   32'h0307_1f1f
`define DIF_RISE_MASK    32'h0300_0000
`define DIF_RST_MASK     32'h0000_0000
`define DIF_RST_PEND     32'h0000_0000
`define DIF_RST_WORD     32'h0000_0000

`endif

// file: rtl/dif_pkg.sv
// types shared by the decoder interrupt flag block
package dif_pkg;
   typedef logic [31:0] dif_word_t;
   typedef logic [7:0]  dif_addr_t;
   typedef logic [7:0]  dif_byte_t;
   typedef logic [14:0] dif_src_t;
   typedef enum logic [1:0] {
      DIF_GRP_STAT = 2'b00,
      DIF_GRP_MASK = 2'b01,
      // group code is address bits [5:4]: 0x00, 0x10, 0x20
      DIF_GRP_PEND = 2'b10
   } dif_grp_t;
endpackage : dif_pkg

// file: tb/dif_host_model.sv
// host side of the interrupt pin: board pull-up resolving the open-drain line
module dif_host_model (
   input  wire logic i_irq_n_out,
   input  wire logic i_irq_n_oe,
   output logic      o_irq_line_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // nobody drives a released line, so the pull-up wins and the host sees it high
   assign o_irq_line_n = i_irq_n_oe ? i_irq_n_out : 1'b1;
endmodule : dif_host_model

// file: tb/decoder_interrupt_flags_bench.sv
// self-checking bench for the decoder interrupt flag block
`include "dif_regs.svh"
module decoder_interrupt_flags_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import dif_pkg::*;
   logic      i_clk_sys, i_rst_n, psel, penable, pwrite, pready, pslverr;
   logic      irq_out, irq_oe, irq_line_n, err;
   logic [3:0] strb;
   dif_addr_t paddr;
   dif_word_t pwdata, prdata, rd;
   dif_src_t  src;
   int        fails, total_checks;

   dif_core i_dut (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(strb),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_power_fail(src[13]), .i_interlaced(src[0]), .i_hpll_locked(src[1]),
      .i_vert_locked(src[2]), .i_field_60hz(src[3]), .i_capture_ready(src[4]),
      .i_color_std(src[6:5]), .i_copy_prot_a(src[7]), .i_copy_prot_b(src[8]),
      .i_copy_prot_c(src[9]), .i_vps_ident(src[10]), .i_widescreen_ident(src[11]),
      .i_caption_ident(src[12]), .i_scaler_format_err(src[14]),
      .o_irq_n_out(irq_out), .o_irq_n_oe(irq_oe));

   dif_host_model i_host (
      .i_irq_n_out(irq_out), .i_irq_n_oe(irq_oe), .o_irq_line_n(irq_line_n));

   initial begin
      i_clk_sys = 1'b0;
      forever #10 i_clk_sys = ~i_clk_sys;
   end

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input dif_word_t got, input dif_word_t exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; holds the request until pready is seen high at an edge
   task automatic apb(input logic wr, input dif_addr_t a, input dif_word_t d);
      int n;
      @(posedge i_clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge i_clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         $display("CHECK FAILED at %0t: no pready", $time);
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input dif_addr_t a, input dif_word_t exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdchk

   task automatic irq_chk(input logic exp);
      chk({31'h0, irq_line_n}, {31'h0, exp});
   endtask : irq_chk

   // expected status word for a given set of source levels
   function automatic dif_word_t live(input dif_src_t s);
      return {6'h0, s[14:13], 5'h0, s[12:10], 3'h0, s[9:5], 3'h0, s[4:0]};
   endfunction : live

   initial begin
      int b;
      dif_addr_t a;
      dif_word_t e;
      i_rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      strb = 4'hf;
      src = '0;
      fails = 0;
      total_checks = 0;
      repeat (2) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      irq_chk(1'b1);
      for (int k = 0; k < 4; k++) begin
         rdchk(`DIF_OFF_MASK + 8'(4 * k), `DIF_RST_MASK);
         rdchk(`DIF_OFF_PEND + 8'(4 * k), `DIF_RST_PEND);
      end
      // every source toggled up then down; power fail and scaler error only flag rising
      for (int i = 0; i < 15; i++) begin
         b = (i < 5) ? 0 : (i < 10) ? 1 : (i < 13) ? 2 : 3;
         a = 8'(4 * b);
         for (int v = 1; v >= 0; v--) begin
            @(posedge i_clk_sys);
            src[i] <= v[0];
            repeat (4) @(posedge i_clk_sys);
            e = (v == 0 && i >= 13) ? 32'h0 : live(dif_src_t'(1) << i) >> (8 * b);
            repeat (2) rdchk(`DIF_OFF_PEND + a, e);
            rdchk(`DIF_OFF_STAT + a, (live(src) >> (8 * b)) & 32'hff);
            rdchk(`DIF_OFF_PEND + a, 32'h0);
         end
      end
      strb <= 4'h0;
      apb(1'b1, `DIF_OFF_MASK, 32'h1f);
      rdchk(`DIF_OFF_MASK, 32'h0);
      strb <= 4'hf;
      apb(1'b1, `DIF_OFF_MASK + 8'h04, 32'h04);
      rdchk(`DIF_OFF_MASK + 8'h04, 32'h04);
      @(posedge i_clk_sys);
      src[8] <= 1'b1;
      src[1] <= 1'b1;
      repeat (6) @(posedge i_clk_sys);
      irq_chk(1'b1);
      src[7] <= 1'b1;
      repeat (6) @(posedge i_clk_sys);
      irq_chk(1'b0);
      rdchk(`DIF_OFF_STAT, live(src) & 32'hff);
      irq_chk(1'b0);
      rdchk(`DIF_OFF_STAT + 8'h04, (live(src) >> 8) & 32'hff);
      repeat (2) @(posedge i_clk_sys);
      irq_chk(1'b1);
      // new event lands on the same edge as the clearing read
      src[1] <= 1'b0;
      apb(1'b0, `DIF_OFF_STAT, 32'h0);
      rdchk(`DIF_OFF_PEND, 32'h02);
      apb(1'b1, `DIF_OFF_STAT, 32'hff);
      chk({31'h0, err}, 32'h1);
      rdchk(`DIF_OFF_PEND, 32'h02);
      apb(1'b1, 8'h30, 32'hff);
      chk({31'h0, err}, 32'h1);
      // the hpll flag is still pending, yet status shows the unlocked level of now
      rdchk(`DIF_OFF_STAT, live(src) & 32'hff);
      rdchk(`DIF_OFF_PEND, 32'h0);
      // reset in mid-run must drop the masks again
      @(posedge i_clk_sys);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      rdchk(`DIF_OFF_MASK + 8'h04, `DIF_RST_MASK);
      irq_chk(1'b1);
      tally_and_finish();
   end
endmodule : decoder_interrupt_flags_bench
